// [rtl/bfs_top.sv]
// bfs_top: fault supervisor of a fluorescent ballast controller.
// assumes phase comes from a sequencer on sys_clk, which leaves run
// phase while power_down is high; comparator inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module bfs_top #(
   parameter logic [31:0] OV_CYC = bfs_pkg::CYC_OV,
   parameter logic [31:0] LAMP_CYC = bfs_pkg::CYC_LAMP,
   parameter logic [31:0] DC_CYC = bfs_pkg::CYC_DC,
   parameter logic [31:0] CAP_CYC = bfs_pkg::CYC_CAP,
   parameter logic [31:0] IGN_CYC = bfs_pkg::CYC_IGN,
   parameter logic [31:0] LATCH_CYC = bfs_pkg::CYC_LATCH,
   parameter logic [31:0] RUNCLR_CYC = bfs_pkg::CYC_RUNCLR
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire bfs_pkg::bfs_phase_t phase,
   input wire logic uvlo_det,
   input wire logic bus_over_hi,
   input wire logic bus_below_rec,
   input wire logic lamp_peak_pos,
   input wire logic lamp_peak_neg,
   input wire logic lamp_dc_pos,
   input wire logic lamp_dc_neg,
   input wire logic cap_load_below_res,
   input wire logic run_freq_reached,
   input wire logic pfc_current_over,
   input wire logic low_side_current_lo,
   input wire logic low_side_current_hi,
   output logic pfc_on_cut,
   output logic ignition_ctrl,
   output logic power_down,
   output logic latched_fault_mode,
   output logic restart_req,
   output logic locked_off
);

   localparam logic [31:0] LIM [bfs_pkg::NCH] = '{
      OV_CYC, LAMP_CYC, DC_CYC, CAP_CYC, IGN_CYC,
      bfs_pkg::CYC_LSC, bfs_pkg::CYC_LSC, bfs_pkg::CYC_LSC,
      bfs_pkg::CYC_PFC, bfs_pkg::CYC_PFC};

   // reset release through two flops
   logic [1:0] rst_sync_ff;
   logic rst_int_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_ff[1];

   // comparator synchronisers; stage one feeds stage two only
   logic [bfs_pkg::NIN-1:0] raw_in;
   logic [bfs_pkg::NIN-1:0] sync1_ff;
   logic [bfs_pkg::NIN-1:0] sync2_ff;

   assign raw_in = {uvlo_det, bus_over_hi, bus_below_rec, lamp_peak_pos,
                    lamp_peak_neg, lamp_dc_pos, lamp_dc_neg,
                    cap_load_below_res, run_freq_reached, pfc_current_over,
                    low_side_current_lo, low_side_current_hi};

   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   logic uvlo_s, ovhi_s, rec_s, lpp_s, lpn_s, ldp_s, ldn_s;
   logic cap_s, runf_s, pfc_s, lsl_s, lsh_s;
   assign {uvlo_s, ovhi_s, rec_s, lpp_s, lpn_s, ldp_s, ldn_s,
           cap_s, runf_s, pfc_s, lsl_s, lsh_s} = sync2_ff;

   // phase decode
   logic in_run, in_ign, in_pre, in_prerun, in_active, in_hi_lim;
   assign in_run = (phase == bfs_pkg::PH_RUN);
   assign in_ign = (phase == bfs_pkg::PH_IGNITION);
   assign in_pre = (phase == bfs_pkg::PH_PREHEAT);
   assign in_prerun = (phase == bfs_pkg::PH_PRERUN);
   assign in_active = (phase != bfs_pkg::PH_POWERUP);
   assign in_hi_lim = (phase == bfs_pkg::PH_STARTUP) ||
                      (phase == bfs_pkg::PH_SOFTSTART) || in_ign || in_prerun;

   logic [bfs_pkg::NCH-1:0] cond;
   logic [bfs_pkg::NCH-1:0] en;
   logic [bfs_pkg::NCH-1:0] fire;

   always_comb begin
      cond = '0;
      en = '0;
      cond[bfs_pkg::CH_OV] = ovhi_s;
      en[bfs_pkg::CH_OV] = in_run;
      cond[bfs_pkg::CH_LAMP] = lpp_s || lpn_s;
      en[bfs_pkg::CH_LAMP] = in_run;
      cond[bfs_pkg::CH_DC] = ldp_s || ldn_s;
      en[bfs_pkg::CH_DC] = in_run;
      cond[bfs_pkg::CH_CAP] = cap_s;
      en[bfs_pkg::CH_CAP] = in_run;
      cond[bfs_pkg::CH_IGN] = !runf_s;
      en[bfs_pkg::CH_IGN] = in_ign;
      cond[bfs_pkg::CH_LSC_LO] = lsl_s;
      en[bfs_pkg::CH_LSC_LO] = in_pre || in_run;
      cond[bfs_pkg::CH_LSC_HI] = lsh_s;
      en[bfs_pkg::CH_LSC_HI] = in_hi_lim;
      cond[bfs_pkg::CH_SURGE] = lsl_s && ovhi_s;
      en[bfs_pkg::CH_SURGE] = in_prerun || in_run;
      cond[bfs_pkg::CH_PFC] = pfc_s;
      en[bfs_pkg::CH_PFC] = in_active;
      cond[bfs_pkg::CH_IGNC] = lsl_s;
      en[bfs_pkg::CH_IGNC] = in_ign;
   end

   genvar g;
   generate
      for (g = 0; g < bfs_pkg::NCH; g++) begin : g_qual
         bfs_qual #(
            .LIMIT(LIM[g])
         ) u_qual (
            .sys_clk(sys_clk),
            .rst_n(rst_int_n),
            .cond(cond[g]),
            .en(en[g]),
            .fire(fire[g])
         );
      end
   endgenerate

   // corrective only: no state change
   assign pfc_on_cut = fire[bfs_pkg::CH_PFC];
   assign ignition_ctrl = fire[bfs_pkg::CH_IGNC];

   logic fault_f;
   assign fault_f = fire[bfs_pkg::CH_LAMP] || fire[bfs_pkg::CH_DC] ||
                    fire[bfs_pkg::CH_CAP] || fire[bfs_pkg::CH_IGN] ||
                    fire[bfs_pkg::CH_LSC_LO] || fire[bfs_pkg::CH_LSC_HI];

   bfs_pkg::bfs_state_t state_ff, nxt_state;
   logic used_ff, nxt_used;
   logic restart_ff, nxt_restart;
   logic [31:0] dly_ff, nxt_dly;
   logic [31:0] run_ff, nxt_run;

   always_comb begin
      nxt_state = state_ff;
      nxt_used = used_ff;
      nxt_restart = 1'b0;
      nxt_dly = 32'h0000_0000;
      nxt_run = 32'h0000_0000;
      if (uvlo_s) begin
         // lockout resets the failure latch from any state
         nxt_state = bfs_pkg::ST_NORMAL;
         nxt_used = 1'b0;
      end else begin
         case (state_ff)
            bfs_pkg::ST_NORMAL: begin
               if (in_run) begin
                  // saturate so the count does not wrap; used_ff is then cleared again on every run cycle
                  if (run_ff == RUNCLR_CYC - 32'h0000_0001) begin
                     nxt_used = 1'b0;
                     nxt_run = run_ff;
                  end else begin
                     nxt_run = run_ff + 32'h0000_0001;
                  end
               end
               // surge first: its overcurrent would also look like F
               if (fire[bfs_pkg::CH_SURGE]) begin
                  nxt_state = bfs_pkg::ST_SURGE_DOWN;
               end else if (fault_f) begin
                  if (used_ff) begin
                     nxt_state = bfs_pkg::ST_LOCKED;
                  end else begin
                     nxt_state = bfs_pkg::ST_LATCH_WAIT;
                  end
               end else if (fire[bfs_pkg::CH_OV]) begin
                  nxt_state = bfs_pkg::ST_OV_DOWN;
               end
            end
            bfs_pkg::ST_OV_DOWN: begin
               if (rec_s) begin
                  nxt_state = bfs_pkg::ST_NORMAL;
               end
            end
            bfs_pkg::ST_SURGE_DOWN: begin
               if (!ovhi_s) begin
                  nxt_state = bfs_pkg::ST_NORMAL;
               end
            end
            bfs_pkg::ST_LATCH_WAIT: begin
               if (dly_ff == LATCH_CYC - 32'h0000_0001) begin
                  nxt_state = bfs_pkg::ST_NORMAL;
                  nxt_restart = 1'b1;
                  nxt_used = 1'b1;
               end else begin
                  nxt_dly = dly_ff + 32'h0000_0001;
               end
            end
            bfs_pkg::ST_LOCKED: begin
               nxt_state = bfs_pkg::ST_LOCKED;
            end
            default: begin
               nxt_state = bfs_pkg::ST_NORMAL;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state_ff <= bfs_pkg::ST_NORMAL;
         used_ff <= 1'b0;
         restart_ff <= 1'b0;
         dly_ff <= 32'h0000_0000;
         run_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         used_ff <= nxt_used;
         restart_ff <= nxt_restart;
         dly_ff <= nxt_dly;
         run_ff <= nxt_run;
      end
   end

   assign power_down = (state_ff != bfs_pkg::ST_NORMAL);
   assign latched_fault_mode = (state_ff == bfs_pkg::ST_LATCH_WAIT) ||
                               (state_ff == bfs_pkg::ST_LOCKED);
   assign locked_off = (state_ff == bfs_pkg::ST_LOCKED);
   assign restart_req = restart_ff;

   a_pfc_cut_phase:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      pfc_on_cut |-> $past(pfc_s) && $past(in_active))
   else $error("pfc cut without overcurrent");

   a_ign_ctrl_phase:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      ignition_ctrl |-> $past(in_ign) && $past(lsl_s))
   else $error("ignition control outside ignition");

   a_ov_run_only:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      $rose(state_ff == bfs_pkg::ST_OV_DOWN) |-> $past(in_run, 2))
   else $error("overvoltage shutdown outside run");

   a_ov_recover:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      (state_ff == bfs_pkg::ST_OV_DOWN) && rec_s |=> !power_down)
   else $error("no recovery below the lower bus level");

   a_surge_recover:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      (state_ff == bfs_pkg::ST_SURGE_DOWN) |=> power_down || !$past(ovhi_s))
   else $error("surge shutdown left while bus still high");

   a_restart_once:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      restart_req |-> used_ff && $past(state_ff) == bfs_pkg::ST_LATCH_WAIT
      ##1 !restart_req)
   else $error("restart not a single pulse after latch wait");

   a_second_lockout:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      (state_ff == bfs_pkg::ST_NORMAL) && used_ff && fault_f &&
      !fire[bfs_pkg::CH_SURGE] && !uvlo_s |=> locked_off [*2])
   else $error("second latched fault did not lock off");

   a_uvlo_clears:
   assert property (@(posedge sys_clk) disable iff (!rst_int_n)
      uvlo_s |=> !used_ff && !power_down)
   else $error("lockout did not clear the failure latch");

endmodule // bfs_top
`default_nettype wire

// [rtl/bfs_pkg.sv]
// bfs_pkg: constants, phases and states of the ballast fault supervisor.
// assumes a 50 MHz system clock; times are least durations, rounded up.
package bfs_pkg;

   localparam longint CLK_HZ = 50_000_000;

   // least durations, in the unit that each name carries
   localparam longint T_OV_MS = 625;
   localparam longint T_LAMP_US = 620;
   localparam longint T_DC_MS = 2500;
   localparam longint T_CAP_US = 620;
   localparam longint T_IGN_MS = 237;
   localparam longint T_PFC_NS = 200;
   localparam longint T_LSC_NS = 500;
   localparam longint T_LATCH_MS = 200;
   localparam longint T_RUNCLR_S = 40;

   localparam logic [31:0] CYC_OV = 32'((T_OV_MS * CLK_HZ + 999) / 1000);
   localparam logic [31:0] CYC_LAMP =
      32'((T_LAMP_US * CLK_HZ + 999_999) / 1_000_000);
   localparam logic [31:0] CYC_DC = 32'((T_DC_MS * CLK_HZ + 999) / 1000);
   localparam logic [31:0] CYC_CAP =
      32'((T_CAP_US * CLK_HZ + 999_999) / 1_000_000);
   localparam logic [31:0] CYC_IGN = 32'((T_IGN_MS * CLK_HZ + 999) / 1000);
   localparam logic [31:0] CYC_PFC =
      32'((T_PFC_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
   localparam logic [31:0] CYC_LSC =
      32'((T_LSC_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
   localparam logic [31:0] CYC_LATCH =
      32'((T_LATCH_MS * CLK_HZ + 999) / 1000);
   localparam logic [31:0] CYC_RUNCLR = 32'(T_RUNCLR_S * CLK_HZ);

   // qualifier channels
   localparam int NCH = 10;
   localparam int CH_OV = 0;
   localparam int CH_LAMP = 1;
   localparam int CH_DC = 2;
   localparam int CH_CAP = 3;
   localparam int CH_IGN = 4;
   localparam int CH_LSC_LO = 5;
   localparam int CH_LSC_HI = 6;
   localparam int CH_SURGE = 7;
   localparam int CH_PFC = 8;
   localparam int CH_IGNC = 9;

   // synchronised inputs
   localparam int NIN = 12;

   typedef enum logic [2:0] {
      PH_POWERUP = 3'h0,
      PH_STARTUP = 3'h1,
      PH_SOFTSTART = 3'h2,
      PH_PREHEAT = 3'h3,
      PH_IGNITION = 3'h4,
      PH_PRERUN = 3'h5,
      PH_RUN = 3'h6
   } bfs_phase_t;

   typedef enum logic [2:0] {
      ST_NORMAL = 3'h0,
      ST_OV_DOWN = 3'h1,
      ST_SURGE_DOWN = 3'h2,
      ST_LATCH_WAIT = 3'h3,
      ST_LOCKED = 3'h4
   } bfs_state_t;

endpackage

// [rtl/bfs_qual.sv]
// bfs_qual: one fault qualifier, fires after LIMIT sampled cycles of cond.
// assumes cond and en are already in the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module bfs_qual #(
   parameter logic [31:0] LIMIT = 32'h0000_0001
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cond,
   input wire logic en,
   output logic fire
);

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic fire_ff;
   logic nxt_fire;

   always_comb begin
      // any gap restarts the count, so only unbroken persistence counts
      if (cond && en) begin
         nxt_cnt = (cnt_ff == LIMIT) ? cnt_ff : cnt_ff + 32'h0000_0001;
      end else begin
         nxt_cnt = 32'h0000_0000;
      end
      nxt_fire = (nxt_cnt == LIMIT);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 32'h0000_0000;
         fire_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         fire_ff <= nxt_fire;
      end
   end

   assign fire = fire_ff;

   a_fire_needs_cond:
   assert property (@(posedge sys_clk) disable iff (!rst_n)
      fire |-> $past(cond) && $past(en))
   else $error("qualifier fired without its condition");

endmodule // bfs_qual
`default_nettype wire

// [bench/bfs_sense_model.sv]
// bfs_sense_model: sense comparators of the lamp inverter and PFC stage.
// assumes the bench calls put just after a rising edge of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module bfs_sense_model (
   output logic bus_over_hi,
   output logic bus_below_rec,
   output logic lamp_peak_pos,
   output logic lamp_peak_neg,
   output logic lamp_dc_pos,
   output logic lamp_dc_neg,
   output logic cap_load_below_res,
   output logic run_freq_reached,
   output logic pfc_current_over,
   output logic low_side_current_lo,
   output logic low_side_current_hi
);
   // bus in range and run frequency reached; all limits quiet
   logic [10:0] lvl = 11'h082;

   assign {low_side_current_hi, low_side_current_lo, pfc_current_over,
      run_freq_reached, cap_load_below_res, lamp_dc_neg, lamp_dc_pos,
      lamp_peak_neg, lamp_peak_pos, bus_below_rec, bus_over_hi} = lvl;

   // bus comparators are set apart so the band 105..109 can be shown
   task automatic put(input logic [10:0] mask, input logic val);
      lvl = val ? (lvl | mask) : (lvl & ~mask);
   endtask
endmodule // bfs_sense_model
`default_nettype wire

// [bench/bfs_top_tb.sv]
// bfs_top_tb: self-checking bench of the ballast fault supervisor.
// assumes shortened qualifier and timer parameters set below.
`timescale 1ns/100ps
`default_nettype none
module bfs_top_tb;
   localparam int OV = 20, LAMP = 16, DC = 40, CAP = 16, IGN = 30;
   localparam int LAT = 12, RCLR = 50, LSC = 25;
   localparam logic [10:0] M_OV = 11'h001, M_REC = 11'h002;
   localparam logic [10:0] M_PP = 11'h004, M_DCN = 11'h020;
   localparam logic [10:0] M_PN = 11'h008, M_DCP = 11'h010;
   localparam logic [10:0] M_CAP = 11'h040, M_RUN = 11'h080;
   localparam logic [10:0] M_PFC = 11'h100, M_LO = 11'h200;
   localparam logic [10:0] M_HI = 11'h400;
   logic sys_clk = 1'b0, rst_n = 1'b0, uvlo_det = 1'b0;
   bfs_pkg::bfs_phase_t phase = bfs_pkg::PH_POWERUP;
   logic bus_over_hi, bus_below_rec, lamp_peak_pos, lamp_peak_neg;
   logic lamp_dc_pos, lamp_dc_neg, cap_load_below_res, run_freq_reached;
   logic pfc_current_over, low_side_current_lo, low_side_current_hi;
   logic pfc_on_cut, ignition_ctrl, power_down, latched_fault_mode;
   logic restart_req, locked_off;
   int errors = 0, comparisons = 0;

   always #10 sys_clk = ~sys_clk;

   bfs_sense_model u_sense (.bus_over_hi(bus_over_hi),
      .bus_below_rec(bus_below_rec), .lamp_peak_pos(lamp_peak_pos),
      .lamp_peak_neg(lamp_peak_neg), .lamp_dc_pos(lamp_dc_pos),
      .lamp_dc_neg(lamp_dc_neg), .cap_load_below_res(cap_load_below_res),
      .run_freq_reached(run_freq_reached),
      .pfc_current_over(pfc_current_over),
      .low_side_current_lo(low_side_current_lo),
      .low_side_current_hi(low_side_current_hi));

   bfs_top #(.OV_CYC(32'(OV)), .LAMP_CYC(32'(LAMP)), .DC_CYC(32'(DC)),
      .CAP_CYC(32'(CAP)), .IGN_CYC(32'(IGN)), .LATCH_CYC(32'(LAT)),
      .RUNCLR_CYC(32'(RCLR))) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .phase(phase), .uvlo_det(uvlo_det), .bus_over_hi(bus_over_hi),
      .bus_below_rec(bus_below_rec), .lamp_peak_pos(lamp_peak_pos),
      .lamp_peak_neg(lamp_peak_neg), .lamp_dc_pos(lamp_dc_pos),
      .lamp_dc_neg(lamp_dc_neg), .cap_load_below_res(cap_load_below_res),
      .run_freq_reached(run_freq_reached),
      .pfc_current_over(pfc_current_over),
      .low_side_current_lo(low_side_current_lo),
      .low_side_current_hi(low_side_current_hi), .pfc_on_cut(pfc_on_cut),
      .ignition_ctrl(ignition_ctrl), .power_down(power_down),
      .latched_fault_mode(latched_fault_mode), .restart_req(restart_req),
      .locked_off(locked_off));

   task automatic chk(input logic seen, input logic exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: %s seen %b wanted %b", $time, msg,
            seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wait_pd();
      int n;
      n = 0;
      while (power_down !== 1'b1 && n < 6) begin
         tick(1);
         n++;
      end
      chk(power_down, 1'b1, "power down");
   endtask

   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic clear_latch();
      uvlo_det = 1'b1;
      tick(4);
      uvlo_det = 1'b0;
      tick(3);
      chk(latched_fault_mode, 1'b0, "latch after uvlo");
      chk(locked_off, 1'b0, "lock after uvlo");
   endtask

   // pfc cut only outside power-up, without any fault
   task automatic t_pfc();
      u_sense.put(M_PFC, 1'b1);
      tick(15);
      chk(pfc_on_cut, 1'b0, "cut in power-up");
      phase = bfs_pkg::PH_STARTUP;
      tick(9);
      chk(pfc_on_cut, 1'b0, "cut early");
      tick(3);
      chk(pfc_on_cut, 1'b1, "cut");
      chk(power_down, 1'b0, "no fault on cut");
      u_sense.put(M_PFC, 1'b0);
      tick(4);
      chk(pfc_on_cut, 1'b0, "cut release");
   endtask

   // one-cycle gap must restart the count
   task automatic t_ignc();
      phase = bfs_pkg::PH_IGNITION;
      u_sense.put(M_LO, 1'b1);
      tick(8);
      u_sense.put(M_LO, 1'b0);
      tick(1);
      u_sense.put(M_LO, 1'b1);
      tick(10);
      chk(ignition_ctrl, 1'b0, "gap restarts");
      tick(3);
      chk(ignition_ctrl, 1'b1, "ignition control");
      chk(power_down, 1'b0, "no shutdown");
      u_sense.put(M_LO, 1'b0);
      tick(4);
   endtask

   task automatic fault(input bfs_pkg::bfs_phase_t ph,
      input logic [10:0] mask, input logic val, input int lim,
      input logic lock);
      int n;
      phase = ph;
      u_sense.put(mask, val);
      tick(lim + 1);
      chk(power_down, 1'b0, "fault early");
      wait_pd();
      chk(latched_fault_mode, 1'b1, "latched mode");
      chk(locked_off, lock, "locked off");
      u_sense.put(mask, ~val);
      phase = bfs_pkg::PH_PREHEAT;
      n = 0;
      while (restart_req !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk(restart_req, !lock, "restart");
      if (!lock) begin
         chk(n == LAT, 1'b1, "latch delay");
         chk(power_down, 1'b0, "up on restart");
         tick(1);
         chk(restart_req, 1'b0, "single pulse");
      end
   endtask

   task automatic t_gate();
      phase = bfs_pkg::PH_PREHEAT;
      u_sense.put(M_OV | M_PP | M_DCN, 1'b1);
      u_sense.put(M_REC, 1'b0);
      tick(OV + 10);
      chk(power_down, 1'b0, "run-only faults");
      u_sense.put(M_OV | M_PP | M_DCN, 1'b0);
      u_sense.put(M_REC, 1'b1);
      tick(3);
   endtask

   task automatic t_bus(input bfs_pkg::bfs_phase_t ph,
      input logic [10:0] mask, input int lim);
      phase = ph;
      u_sense.put(mask | M_OV, 1'b1);
      u_sense.put(M_REC, 1'b0);
      tick(lim + 1);
      chk(power_down, 1'b0, "bus early");
      wait_pd();
      chk(latched_fault_mode, 1'b0, "auto-restart class");
      u_sense.put(mask, 1'b0);
      phase = bfs_pkg::PH_PREHEAT;
      tick(6);
      chk(power_down, 1'b1, "bus hold");
      u_sense.put(M_OV, 1'b0);
      tick(6);
      chk(power_down, ph == bfs_pkg::PH_RUN, "band 105..109");
      u_sense.put(M_REC, 1'b1);
      tick(4);
      chk(power_down, 1'b0, "recovered");
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      chk(power_down | latched_fault_mode | restart_req | locked_off,
         1'b0, "reset outputs");
      tick(5);
      t_pfc();
      t_ignc();
      t_gate();
      t_bus(bfs_pkg::PH_RUN, 11'h000, OV);
      t_bus(bfs_pkg::PH_PRERUN, M_LO, LSC);
      fault(bfs_pkg::PH_RUN, M_PP, 1'b1, LAMP, 1'b0);
      fault(bfs_pkg::PH_RUN, M_CAP, 1'b1, CAP, 1'b1);
      tick(30);
      chk(locked_off, 1'b1, "stays locked");
      clear_latch();
      fault(bfs_pkg::PH_RUN, M_DCN, 1'b1, DC, 1'b0);
      phase = bfs_pkg::PH_RUN;
      tick(RCLR + 5);
      fault(bfs_pkg::PH_RUN, M_LO, 1'b1, LSC, 1'b0);
      clear_latch();
      fault(bfs_pkg::PH_STARTUP, M_HI, 1'b1, LSC, 1'b0);
      fault(bfs_pkg::PH_IGNITION, M_RUN, 1'b0, IGN, 1'b1);
      clear_latch();
      fault(bfs_pkg::PH_RUN, M_PN, 1'b1, LAMP, 1'b0);
      fault(bfs_pkg::PH_RUN, M_DCP, 1'b1, DC, 1'b1);
      clear_latch();
      fault(bfs_pkg::PH_SOFTSTART, M_HI, 1'b1, LSC, 1'b0);
      report_and_stop();
   end

   // whole run needs about 750 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      report_and_stop();
   end
endmodule // bfs_top_tb
`default_nettype wire
